// *** two_wire_regs.svh ***
// Offsets, field positions, reset values and timing counts of the two-wire link
`ifndef TWO_WIRE_REGS_SVH
`define TWO_WIRE_REGS_SVH

// ==========================================================
// Clock and link timing
`define CLK_HZ          20000000
`define CLK_PERIOD_NS   50
// Link period of 1 us: the far end reacts three aclk after a fall, well inside the low quarter
`define SCL_PERIOD_NS   1000
`define SCL_QUARTER     (`SCL_PERIOD_NS / (4 * `CLK_PERIOD_NS))
`define TWC_US          5000
`define TWC_CYCLES_DFLT (`TWC_US * (`CLK_HZ / 1000000))
`define SOFT_RESET_ONES 18

// ==========================================================
// Memory geometry and device address word
`define PAGE_BYTES      16
`define DEV_TYPE_CODE   4'hA

// ==========================================================
// Controller register offsets
`define REG_CTRL        8'h00
`define REG_ADDR        8'h04
`define REG_WDATA       8'h08
`define REG_STATUS      8'h0C

// ==========================================================
// Controller fields and reset values
`define CTRL_CMD_LSB    0
`define ADDR_WORD_LSB   0
`define ADDR_CS_LSB     8
`define STAT_BUSY_BIT   0
`define STAT_NACK_BIT   1
`define STAT_RDATA_LSB  8
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define ADDR_RESET      8'h00
`define DATA_RESET      8'h00

`endif

// *** two_wire_pkg.sv ***
// Types shared by both ends of the two-wire link
package two_wire_pkg;

	// ==========================================================
	// Device protocol states
	typedef enum logic [3:0] {
		ST_IDLE, ST_DEV, ST_ACK_DEV, ST_WADDR, ST_WDATA, ST_ACK_W, ST_RDATA, ST_RACK, ST_IGNORE
	} dev_state_t;

	// ==========================================================
	// Controller commands and bus operations
	typedef enum logic [2:0] {
		CMD_NONE, CMD_WRITE, CMD_RAND, CMD_CUR, CMD_RESET, CMD_POLL
	} cmd_t;

	typedef enum logic [2:0] {
		OP_START, OP_TX, OP_RX, OP_STOP, OP_ONES, OP_END
	} op_t;

endpackage

// *** two_wire_bus_if.sv ***
// Two-wire bus carrier: open-drain data wire resolved from both drivers
`timescale 1ns/100ps
interface two_wire_bus_if;
	logic scl;
	logic host_sda_out;
	logic host_sda_oe_n;
	logic dev_sda_out;
	logic dev_sda_oe_n;
	logic sda;

	// Pull-up wins unless an enabled driver pulls low
	assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);

	modport device (input scl, input sda, output dev_sda_out, output dev_sda_oe_n);
	modport host (output scl, output host_sda_out, output host_sda_oe_n, input sda);
endinterface

// *** pin_sync.sv ***
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	// ==========================================================
	// First stage is read only by the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// *** two_wire_eeprom_slave.sv ***
// Slave end: two-wire serial front of a 256 x 8 nonvolatile array
//
// Function
// - Sample on clock rise, drive on fall
// - Data line is open-drain only
// - Unconnected straps read as low; this model has no pull-down and samples the straps as driven
// - Write-protect high blocks all programming
// - Reads ignore write-protect level
// - Sixteen pages of sixteen bytes, 8-bit address
// - Master changes data only while clock low
// - Data fall with clock high is START
// - Data rise with clock high is STOP
// - STOP after write starts programming, read idles
// - Acknowledge each word low on ninth clock
// - Standby after reset, read STOP, programming
// - START, eighteen ones, START resets slave
// - Address word high nibble must be 1010
// - Chip-select bits match straps or no ack
// - Eighth address bit selects read or write
// - Five-pin variant compares chip-select as zero
// - Page writes up to sixteen bytes, partial allowed
// - Programming self-timed, at most 5 ms
// - Column increments and wraps within page
// - No address ack while programming busy
// - Address counter increments after reads, rolls over
`timescale 1ns/100ps
`include "two_wire_regs.svh"
module two_wire_eeprom_slave import two_wire_pkg::*; #(
	parameter int unsigned TWC_CYCLES = `TWC_CYCLES_DFLT,
	parameter bit          FIVE_PIN   = 1'b0
) (
	input  wire logic      aclk,
	input  wire logic      aresetn,
	two_wire_bus_if.device bus,
	input  wire logic      chip_select_strap_hi,
	input  wire logic      chip_select_strap_mid,
	input  wire logic      chip_select_strap_lo,
	input  wire logic      write_protect,
	output logic           standby,
	output logic           prog_busy
);
	localparam int TW = $clog2(TWC_CYCLES + 1);

	logic [5:0]  sync_q;
	logic        scl_s, sda_s, scl_d, sda_d, wp_s;
	logic [2:0]  strap_s, cs_cmp;
	logic        scl_rise, scl_fall, start_ev, stop_ev;
	dev_state_t  state_reg;
	logic [3:0]  cnt_reg;
	logic [7:0]  sh_reg, rd_byte_reg, addr_ptr_reg;
	logic [3:0]  row_reg, col_reg;
	logic        more_reg, sda_oe_n_reg;
	logic [7:0]  mem [256];
	logic [7:0]  pbuf [`PAGE_BYTES];
	logic [`PAGE_BYTES-1:0] mask_reg;
	logic [TW-1:0] timer_reg;
	logic        word_done, waddr_done, data_done, rd_done, rd_load, dev_match, prog_start;

	// ==========================================================
	// Pin synchronisation and bus event detection
	pin_sync #(.WIDTH(6)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({bus.scl, bus.sda, chip_select_strap_hi, chip_select_strap_mid,
		           chip_select_strap_lo, write_protect}),
		.q       (sync_q)
	);
	assign {scl_s, sda_s, strap_s, wp_s} = sync_q;

	// Delayed copies read only synchronised levels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

	// Five-pin variant compares chip-select as zero; otherwise the synchronised strap levels are compared
	assign cs_cmp = FIVE_PIN ? 3'h0 : strap_s;

	// ==========================================================
	// Word completion decode
	always_comb begin
		word_done  = scl_fall && (cnt_reg == 4'h8);
		dev_match  = (sh_reg[7:4] == `DEV_TYPE_CODE) && (sh_reg[3:1] == cs_cmp) && !prog_busy;
		waddr_done = word_done && (state_reg == ST_WADDR);
		data_done  = word_done && (state_reg == ST_WDATA);
		rd_done    = word_done && (state_reg == ST_RDATA);
		rd_load    = scl_fall && (((state_reg == ST_ACK_DEV) && sh_reg[0]) || ((state_reg == ST_RACK) && more_reg));
		prog_start = stop_ev && ((state_reg == ST_WDATA) || (state_reg == ST_ACK_W))
		             && (mask_reg != '0) && !wp_s;
	end

	// ==========================================================
	// Protocol state machine, bit counter and line driver
	// A START from any state restarts decoding, which also gives the soft reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg    <= ST_IDLE;
			cnt_reg      <= 4'h0;
			sh_reg       <= 8'h00;
			rd_byte_reg  <= 8'h00;
			more_reg     <= 1'b0;
			sda_oe_n_reg <= 1'b1;
		end else if (start_ev) begin
			state_reg    <= ST_DEV;
			cnt_reg      <= 4'h0;
			sda_oe_n_reg <= 1'b1;
		end else if (stop_ev) begin
			state_reg    <= ST_IDLE;
			sda_oe_n_reg <= 1'b1;
		end else begin
			if (rd_load) begin
				rd_byte_reg  <= mem[addr_ptr_reg];
				sda_oe_n_reg <= mem[addr_ptr_reg][7];
				state_reg    <= ST_RDATA;
				cnt_reg      <= 4'h0;
			end else begin
				unique case (state_reg)
					ST_DEV, ST_WADDR, ST_WDATA: begin
						if (scl_rise) begin
							sh_reg  <= {sh_reg[6:0], sda_s};
							cnt_reg <= cnt_reg + 4'h1;
						end else if (word_done && state_reg == ST_DEV) begin
							if (dev_match) begin
								sda_oe_n_reg <= 1'b0;
								state_reg    <= ST_ACK_DEV;
							end else begin
								state_reg <= ST_IGNORE;
							end
						end else if (word_done) begin
							sda_oe_n_reg <= 1'b0;
							state_reg    <= ST_ACK_W;
						end
					end
					ST_ACK_DEV: begin
						if (scl_fall) begin
							sda_oe_n_reg <= 1'b1;
							state_reg    <= ST_WADDR;
							cnt_reg      <= 4'h0;
						end
					end
					ST_ACK_W: begin
						if (scl_fall) begin
							sda_oe_n_reg <= 1'b1;
							state_reg    <= ST_WDATA;
							cnt_reg      <= 4'h0;
						end
					end
					ST_RDATA: begin
						if (scl_rise) begin
							cnt_reg <= cnt_reg + 4'h1;
						end else if (rd_done) begin
							sda_oe_n_reg <= 1'b1;
							state_reg    <= ST_RACK;
						end else if (scl_fall && cnt_reg != 4'h0) begin
							sda_oe_n_reg <= rd_byte_reg[3'(4'h7 - cnt_reg)];
						end
					end
					ST_RACK: begin
						if (scl_rise) begin
							more_reg <= ~sda_s;
						end else if (scl_fall) begin
							state_reg <= ST_IGNORE;
						end
					end
					ST_IDLE, ST_IGNORE: begin
						sda_oe_n_reg <= 1'b1;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Address counter, page row and column, page buffer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_ptr_reg <= 8'h00;
			row_reg      <= 4'h0;
			col_reg      <= 4'h0;
		end else if (waddr_done) begin
			addr_ptr_reg <= sh_reg;
			row_reg      <= sh_reg[7:4];
			col_reg      <= sh_reg[3:0];
		end else if (data_done) begin
			pbuf[col_reg] <= sh_reg;
			col_reg       <= col_reg + 4'h1;
			addr_ptr_reg  <= {row_reg, col_reg + 4'h1};
		end else if (rd_done) begin
			addr_ptr_reg <= addr_ptr_reg + 8'h01;
		end
	end

	// ==========================================================
	// Self-timed programming: array is written only when the timer expires
	// Single commit of the masked page bytes keeps the array untouched if a START aborts early
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prog_busy <= 1'b0;
			timer_reg <= '0;
			mask_reg  <= '0;
		end else if (prog_busy) begin
			if (timer_reg == TW'(1)) begin
				prog_busy <= 1'b0;
				mask_reg  <= '0;
				for (int i = 0; i < `PAGE_BYTES; i++) begin
					if (mask_reg[i]) begin
						mem[{row_reg, 4'(i)}] <= pbuf[i];
					end
				end
			end
			timer_reg <= timer_reg - TW'(1);
		end else if (prog_start) begin
			prog_busy <= 1'b1;
			timer_reg <= TW'(TWC_CYCLES);
		end else if (start_ev || stop_ev) begin
			mask_reg <= '0;
		end else if (data_done) begin
			mask_reg[col_reg] <= 1'b1;
		end
	end

	// Standby flag: no transfer decoding and no programming running
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			standby <= 1'b1;
		end else begin
			standby <= (state_reg == ST_IDLE || state_reg == ST_IGNORE) && !prog_busy;
		end
	end

	assign bus.dev_sda_oe_n = sda_oe_n_reg;
	assign bus.dev_sda_out  = 1'b0;
endmodule

// *** two_wire_master_ctrl.sv ***
// Master end: AXI4-Lite controlled two-wire command sequencer
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/100ps
`include "two_wire_regs.svh"
module two_wire_master_ctrl import two_wire_pkg::*; #(
	parameter int QUARTER = `SCL_QUARTER
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	two_wire_bus_if.host     bus,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	logic [7:0]  awaddr_reg, word_reg, wdata_reg, rdata_reg, sh_reg;
	logic [31:0] wbus_reg;
	logic        aw_got, w_got, go_reg, busy_reg, nack_reg, abort_reg, sda_s;
	logic [2:0]  cs_reg;
	cmd_t        cmd_reg;
	op_t         op_reg;
	logic [3:0]  seq_reg;
	logic [1:0]  q_reg;
	logic [4:0]  bit_reg, nbits;
	logic [7:0]  div_reg;
	logic        tick, last_bit, scl_reg, oe_n_reg;
	logic [7:0]  tx_cur;

	// ==========================================================
	// Command step tables
	function automatic op_t step_op(cmd_t c, logic [3:0] s);
		op_t o;
		o = OP_END;
		unique case (c)
			CMD_WRITE: o = (s == 4'h0) ? OP_START : (s < 4'h4) ? OP_TX : (s == 4'h4) ? OP_STOP : OP_END;
			CMD_RAND:  o = (s == 4'h0 || s == 4'h3) ? OP_START : (s < 4'h5) ? OP_TX :
			               (s == 4'h5) ? OP_RX : (s == 4'h6) ? OP_STOP : OP_END;
			CMD_CUR:   o = (s == 4'h0) ? OP_START : (s == 4'h1) ? OP_TX : (s == 4'h2) ? OP_RX :
			               (s == 4'h3) ? OP_STOP : OP_END;
			CMD_RESET: o = (s == 4'h0 || s == 4'h2) ? OP_START : (s == 4'h1) ? OP_ONES :
			               (s == 4'h3) ? OP_STOP : OP_END;
			CMD_POLL:  o = (s == 4'h0) ? OP_START : (s == 4'h1) ? OP_TX : (s == 4'h2) ? OP_STOP : OP_END;
			default:   o = OP_END;
		endcase
		return o;
	endfunction

	// Device word: type code, chip select, direction
	function automatic logic [7:0] tx_byte(cmd_t c, logic [3:0] s, logic [2:0] cs, logic [7:0] a, logic [7:0] d);
		logic [7:0] b;
		if ((c == CMD_RAND && s == 4'h4) || (c == CMD_CUR && s == 4'h1)) begin
			b = {`DEV_TYPE_CODE, cs, 1'b1};
		end else if (s == 4'h1) begin
			b = {`DEV_TYPE_CODE, cs, 1'b0};
		end else begin
			b = (s == 4'h2) ? a : d;
		end
		return b;
	endfunction

	pin_sync #(.WIDTH(1)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (bus.sda),
		.q       (sda_s)
	);

	// ==========================================================
	// AXI4-Lite slave; address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			awaddr_reg    <= 8'h00;
			wbus_reg      <= 32'h0000_0000;
			go_reg        <= 1'b0;
			cmd_reg       <= CMD_NONE;
			cs_reg        <= 3'h0;
			word_reg      <= `ADDR_RESET;
			wdata_reg     <= `DATA_RESET;
		end else begin
			go_reg <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_reg    <= s_axi_awaddr;
				aw_got        <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wbus_reg     <= s_axi_wdata;
				w_got        <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_got && w_got && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `RESP_OKAY;
				aw_got       <= 1'b0;
				w_got        <= 1'b0;
				unique case (awaddr_reg)
					`REG_CTRL: if (!busy_reg && !go_reg) begin
						cmd_reg <= cmd_t'(wbus_reg[`CTRL_CMD_LSB +: 3]);
						go_reg  <= wbus_reg[`CTRL_CMD_LSB +: 3] != 3'h0;
					end
					`REG_ADDR: begin
						word_reg <= wbus_reg[`ADDR_WORD_LSB +: 8];
						cs_reg   <= wbus_reg[`ADDR_CS_LSB +: 3];
					end
					`REG_WDATA:  wdata_reg <= wbus_reg[7:0];
					`REG_STATUS: ;
					default:     s_axi_bresp <= `RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read channel answers one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `RESP_OKAY;
			unique case (s_axi_araddr)
				`REG_CTRL:   s_axi_rdata <= {29'h0, cmd_reg};
				`REG_ADDR:   s_axi_rdata <= {21'h0, cs_reg, word_reg};
				`REG_WDATA:  s_axi_rdata <= {24'h0, wdata_reg};
				`REG_STATUS: s_axi_rdata <= {16'h0, rdata_reg, 6'h0, nack_reg, busy_reg};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================================
	// Bit engine: four quarters per bit, clock made by division
	assign tick     = (div_reg == 8'(QUARTER - 1));
	assign nbits    = (op_reg == OP_ONES) ? 5'd`SOFT_RESET_ONES : (op_reg == OP_TX || op_reg == OP_RX) ? 5'd9 : 5'd1;
	assign last_bit = (bit_reg == nbits - 5'd1);
	assign tx_cur   = tx_byte(cmd_reg, seq_reg, cs_reg, word_reg, wdata_reg);

	always_ff @(posedge aclk) begin
		if (!aresetn || !busy_reg) begin
			div_reg <= 8'h00;
		end else begin
			div_reg <= tick ? 8'h00 : div_reg + 8'h01;
		end
	end

	// Data changes only in quarter 0 with clock low, except START and STOP
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_reg  <= 1'b0;
			nack_reg  <= 1'b0;
			abort_reg <= 1'b0;
			op_reg    <= OP_END;
			seq_reg   <= 4'h0;
			q_reg     <= 2'h0;
			bit_reg   <= 5'h0;
			sh_reg    <= 8'h00;
			rdata_reg <= 8'h00;
			scl_reg   <= 1'b1;
			oe_n_reg  <= 1'b1;
		end else if (go_reg) begin
			busy_reg  <= 1'b1;
			nack_reg  <= 1'b0;
			abort_reg <= 1'b0;
			seq_reg   <= 4'h0;
			op_reg    <= OP_START;
			q_reg     <= 2'h0;
			bit_reg   <= 5'h0;
		end else if (busy_reg && op_reg == OP_END) begin
			busy_reg <= 1'b0;
		end else if (busy_reg && tick) begin
			q_reg <= q_reg + 2'h1;
			unique case (q_reg)
				2'h0: begin
					scl_reg <= 1'b0;
					unique case (op_reg)
						OP_START: oe_n_reg <= 1'b1;
						OP_STOP:  oe_n_reg <= 1'b0;
						OP_TX: begin
							oe_n_reg <= (bit_reg < 5'd8) ? tx_cur[3'(5'd7 - bit_reg)] : 1'b1;
						end
						default:  oe_n_reg <= 1'b1;
					endcase
				end
				2'h1: scl_reg <= 1'b1;
				2'h2: begin
					if (op_reg == OP_START) oe_n_reg <= 1'b0;
					if (op_reg == OP_STOP) oe_n_reg <= 1'b1;
				end
				2'h3: begin
					scl_reg <= (op_reg == OP_STOP);
					bit_reg <= last_bit ? 5'h0 : bit_reg + 5'h1;
					if (op_reg == OP_RX && bit_reg < 5'd8) sh_reg <= {sh_reg[6:0], sda_s};
					if (last_bit) begin
						seq_reg <= seq_reg + 4'h1;
						op_reg  <= abort_reg ? OP_END : step_op(cmd_reg, seq_reg + 4'h1);
						if (op_reg == OP_RX) rdata_reg <= sh_reg;
						if (op_reg == OP_TX && sda_s) begin
							nack_reg  <= 1'b1;
							abort_reg <= 1'b1;
							op_reg    <= OP_STOP;
						end
					end
				end
			endcase
		end
	end

	assign bus.scl           = scl_reg;
	assign bus.host_sda_oe_n = oe_n_reg;
	assign bus.host_sda_out  = 1'b0;
endmodule

// *** two_wire_monitor.sv ***
// Concurrent checks on the two-wire carrier and the slave status pins
`timescale 1ns/100ps
module two_wire_monitor #(
	parameter int unsigned TWC_CYCLES = 200
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_out,
	input wire logic dev_sda_oe_n,
	input wire logic write_protect,
	input wire logic standby,
	input wire logic prog_busy
);
	// ====================
	// Wire events
	logic        scl_q;
	logic        sda_q;
	logic        stop_seen;
	logic [4:0]  rises;
	logic [31:0] busy_cnt;

	assign stop_seen = scl & scl_q & ~sda_q & sda;

	// Last wire levels, for edge finding
	always_ff @(posedge aclk) begin
		scl_q <= scl;
		sda_q <= sda;
	end

	// Clock rises since START; saturates so a long read never looks like a new frame
	always_ff @(posedge aclk) begin
		if (!aresetn || (scl && scl_q && sda_q && !sda)) rises <= 5'h00;
		else if (scl && !scl_q && rises != 5'h1F) rises <= rises + 5'h01;
	end

	// Length of the running programming cycle
	always_ff @(posedge aclk) begin
		if (!aresetn || !prog_busy) busy_cnt <= 32'h0;
		else busy_cnt <= busy_cnt + 32'h1;
	end

	// ====================
	// Properties
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_open_drain_only: assert property (dev_sda_out == 1'b0 && (dev_sda_oe_n || !sda))
		else $error("device data output not open-drain");
	a_change_scl_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
		else $error("device data changed with clock high");
	a_ack_ninth_clk: assert property (scl && !scl_q && !dev_sda_oe_n && rises < 5'h09 |-> rises == 5'h08)
		else $error("device pulled low before the ninth clock");
	a_busy_no_ack: assert property (prog_busy |-> dev_sda_oe_n)
		else $error("device drove data while programming");
	a_busy_not_idle: assert property (prog_busy |-> !standby)
		else $error("standby shown during programming");
	a_stop_settles: assert property (stop_seen |-> ##[1:8] (standby || prog_busy))
		else $error("no standby or programming after stop");
	a_protect_blocks: assert property (stop_seen && write_protect && !prog_busy |=> !prog_busy [*8])
		else $error("programming started while protected");
	a_prog_time: assert property ($fell(prog_busy) |-> busy_cnt >= TWC_CYCLES - 1 && busy_cnt <= TWC_CYCLES + 1)
		else $error("programming time off");
	a_reset_standby: assert property ($rose(aresetn) |-> standby && !prog_busy)
		else $error("not in standby after reset");
endmodule

// *** two_wire_eeprom_slave_front_tb.sv ***
// Bench joining the AXI4-Lite two-wire master and the serial memory slave
`timescale 1ns/100ps
`include "two_wire_regs.svh"
module two_wire_eeprom_slave_front_tb import two_wire_pkg::*; ();
	localparam int unsigned TWC = 600;
	logic        aclk;
	logic        aresetn;
	logic [2:0]  straps;
	logic        write_protect;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic        wvalid;
	logic        wready;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic [1:0]  bresp;
	logic [1:0]  wresp;
	logic        rvalid;
	logic        rready;
	logic        standby;
	logic        prog_busy;
	logic        nack;
	logic [7:0]  rbyte;
	int          miscompares;
	int          checks;

	two_wire_bus_if link ();

	// ====================
	// Both ends face each other on one carrier; the monitor watches the wire
	two_wire_eeprom_slave #(.TWC_CYCLES(TWC), .FIVE_PIN(1'b0)) u_two_wire_eeprom_slave (
		.aclk(aclk), .aresetn(aresetn), .bus(link), .chip_select_strap_hi(straps[2]),
		.chip_select_strap_mid(straps[1]), .chip_select_strap_lo(straps[0]), .write_protect(write_protect),
		.standby(standby), .prog_busy(prog_busy));
	two_wire_master_ctrl #(.QUARTER(`SCL_QUARTER)) u_two_wire_master_ctrl (
		.aclk(aclk), .aresetn(aresetn), .bus(link), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	two_wire_monitor #(.TWC_CYCLES(TWC)) u_two_wire_monitor (
		.aclk(aclk), .aresetn(aresetn), .scl(link.scl), .sda(link.sda), .dev_sda_out(link.dev_sda_out),
		.dev_sda_oe_n(link.dev_sda_oe_n), .write_protect(write_protect), .standby(standby),
		.prog_busy(prog_busy));

	// Clock at 20 MHz
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// ====================
	// Report and compare
	task automatic conclude();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask

	// Bounded wait for a level at a clock edge; running out ends the run
	task automatic wait_lvl(ref logic sig, input logic lvl);
		int n;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (sig !== lvl && n < 1000);
		if (sig !== lvl) begin
			chk_bit(sig, lvl);
			conclude();
		end
	endtask

	// ====================
	// AXI4-Lite master; a spare edge at the end keeps drives one per time step
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			wait_lvl(aclk, 1'b1);
			aw_ok = aw_ok | (awready === 1'b1);
			w_ok = w_ok | (wready === 1'b1);
			awvalid <= ~aw_ok;
			wvalid <= ~w_ok;
		end
		wait_lvl(bvalid, 1'b1);
		wresp = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		wait_lvl(arready, 1'b1);
		arvalid <= 1'b0;
		wait_lvl(rvalid, 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	// One link command through the registers, then poll until the engine is idle
	task automatic run(input cmd_t c, input logic [2:0] cs, input logic [7:0] w, input logic [7:0] d);
		logic [31:0] st;
		logic [1:0]  r;
		int          n;
		axi_wr(`REG_ADDR, {21'h0, cs, w});
		axi_wr(`REG_WDATA, {24'h0, d});
		axi_wr(`REG_CTRL, {29'h0, c});
		chk_byte({6'h00, wresp}, {6'h00, `RESP_OKAY});
		n = 0;
		do begin
			axi_rd(`REG_STATUS, st, r);
			n++;
		end while (st[`STAT_BUSY_BIT] !== 1'b0 && n < 400);
		chk_bit(st[`STAT_BUSY_BIT], 1'b0);
		if (st[`STAT_BUSY_BIT] !== 1'b0) conclude();
		nack = st[`STAT_NACK_BIT];
		rbyte = st[`STAT_RDATA_LSB +: 8];
	endtask

	task automatic wr_byte(input logic [7:0] w, input logic [7:0] d);
		run(CMD_WRITE, 3'h5, w, d);
		wait_lvl(prog_busy, 1'b1);
		wait_lvl(prog_busy, 1'b0);
	endtask

	// ====================
	// Scenarios
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(8'h10, d, r);
		chk_byte({6'h00, r}, {6'h00, `RESP_SLVERR});
		chk_byte(d[7:0], 8'h00);
		axi_wr(8'h10, 32'h0000_0000);
		chk_byte({6'h00, wresp}, {6'h00, `RESP_SLVERR});
		chk_bit(standby, 1'b1);
		$display("t_regs done");
	endtask

	// Byte write, poll while busy, read back
	task automatic t_write();
		run(CMD_WRITE, 3'h5, 8'h35, 8'hA5);
		chk_bit(nack, 1'b0);
		wait_lvl(prog_busy, 1'b1);
		chk_bit(standby, 1'b0);
		run(CMD_POLL, 3'h5, 8'h00, 8'h00);
		chk_bit(nack, 1'b1);
		wait_lvl(prog_busy, 1'b0);
		wait_lvl(standby, 1'b1);
		run(CMD_RAND, 3'h5, 8'h35, 8'h00);
		chk_byte(rbyte, 8'hA5);
		wait_lvl(standby, 1'b1);
		$display("t_write done");
	endtask

	// Top address then the counter wraps to zero
	task automatic t_roll();
		wr_byte(8'hFF, 8'h3C);
		wr_byte(8'h00, 8'hC3);
		run(CMD_RAND, 3'h5, 8'hFF, 8'h00);
		chk_byte(rbyte, 8'h3C);
		run(CMD_CUR, 3'h5, 8'h00, 8'h00);
		chk_byte(rbyte, 8'hC3);
		$display("t_roll done");
	endtask

	task automatic t_mismatch();
		run(CMD_WRITE, 3'h2, 8'h35, 8'h99);
		chk_bit(nack, 1'b1);
		chk_bit(prog_busy, 1'b0);
		run(CMD_RAND, 3'h5, 8'h35, 8'h00);
		chk_byte(rbyte, 8'hA5);
		$display("t_mismatch done");
	endtask

	task automatic t_protect();
		write_protect <= 1'b1;
		run(CMD_WRITE, 3'h5, 8'h35, 8'h5A);
		chk_bit(nack, 1'b0);
		chk_bit(prog_busy, 1'b0);
		run(CMD_RAND, 3'h5, 8'h35, 8'h00);
		chk_byte(rbyte, 8'hA5);
		write_protect <= 1'b0;
		$display("t_protect done");
	endtask

	task automatic t_soft();
		run(CMD_RESET, 3'h5, 8'h00, 8'h00);
		wait_lvl(standby, 1'b1);
		run(CMD_RAND, 3'h5, 8'h00, 8'h00);
		chk_byte(rbyte, 8'hC3);
		$display("t_soft done");
	endtask

	// Straps left low behave as zeros
	task automatic t_straps_low();
		straps <= 3'h0;
		run(CMD_RAND, 3'h0, 8'hFF, 8'h00);
		chk_bit(nack, 1'b0);
		chk_byte(rbyte, 8'h3C);
		straps <= 3'h5;
		$display("t_straps_low done");
	endtask

	// Main sequence
	initial begin
		aresetn = 1'b0;
		straps = 3'h5;
		write_protect = 1'b0;
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		miscompares = 0;
		checks = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		t_regs();
		t_write();
		t_roll();
		t_mismatch();
		t_protect();
		t_soft();
		t_straps_low();
		conclude();
	end
endmodule
